// ---- core/tci_irq_status.sv ----
// counter wrap latch and interrupt status words of the t1 framer
module tci_irq_status #(
	parameter int TICK_CYCLES = tci_pkg::MS_TICK_CYCLES
) (
	// clock and reset
	input wire logic            clk_sys,
	input wire logic            resetn,
	// processor read port
	input wire logic            cpu_rd,
	input wire logic [7:0]      cpu_addr,
	output logic [7:0]          cpu_rdata,
	output logic                cpu_rvalid,
	// masks from the mask registers
	input wire logic [7:0]      line_event_mask,
	input wire logic [7:0]      counter_wrap_mask,
	input wire logic [7:0]      link_event_mask,
	// low bytes of the monitoring counters, index is the bit position
	input wire logic [7:0][7:0] wrap_cnt,
	// line events, one bit per status bit
	input wire logic [7:0]      line_event,
	// link and timer sources
	input wire logic            fdl_ctrl_event,
	input wire logic            ch24_ctrl_event,
	input wire logic            loop_pattern_event,
	input wire logic            one_second_flag,
	input wire logic            five_second_flag,
	input wire logic            bit_message_event,
	input wire logic [3:0]      sig_bits,
	input wire logic            signaling_debounce_en
);

	localparam logic [16:0] TICK_LAST = 17'(TICK_CYCLES - 1);

	logic [7:0][7:0] prev_cnt;
	logic [7:0]      wrap_evt;
	logic            one_second_prev;
	logic            five_second_prev;
	logic            signaling_change;
	logic [16:0]     tick_cnt;
	logic            tick_ms;
	logic [7:0]      link_set;
	logic [7:0]      next_rdata;
	logic [3:0]      rd_clr;
	logic [7:0]      sets  [tci_pkg::NUM_WORDS];
	logic [7:0]      masks [tci_pkg::NUM_WORDS];
	logic [7:0]      words [tci_pkg::NUM_WORDS];

	tci_word_if wif [tci_pkg::NUM_WORDS] ();

	// ----------------------------------------------------------------
	// status word holders
	// ----------------------------------------------------------------
	for (genvar g = 0; g < tci_pkg::NUM_WORDS; g++) begin : g_word
		assign wif[g].set  = sets[g];
		assign wif[g].mask = masks[g];
		assign wif[g].clr  = rd_clr[g];
		assign words[g]    = wif[g].word;
		tci_sticky_word u_word (
			.clk_sys (clk_sys),
			.resetn  (resetn),
			.wp      (wif[g])
		);
	end

	// ----------------------------------------------------------------
	// counter wrap detection
	// ----------------------------------------------------------------
	// reset to the wrap target so a reset can never look like a wrap
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			prev_cnt <= {8{tci_pkg::WRAP_TO}};
		end else begin
			prev_cnt <= wrap_cnt;
		end
	end

	for (genvar c = 0; c < 8; c++) begin : g_wrap
		assign wrap_evt[c] = (prev_cnt[c] == tci_pkg::WRAP_FROM)
			&& (wrap_cnt[c] == tci_pkg::WRAP_TO);
	end

	// ----------------------------------------------------------------
	// timer flag edges
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			one_second_prev  <= 1'b0;
			five_second_prev <= 1'b0;
		end else begin
			one_second_prev  <= one_second_flag;
			five_second_prev <= five_second_flag;
		end
	end

	// ----------------------------------------------------------------
	// millisecond enable for the signaling debounce
	// ----------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			tick_cnt <= 17'h00000;
			tick_ms  <= 1'b0;
		end else if (tick_cnt == TICK_LAST) begin
			tick_cnt <= 17'h00000;
			tick_ms  <= 1'b1;
		end else begin
			tick_cnt <= tick_cnt + 17'h00001;
			tick_ms  <= 1'b0;
		end
	end

	tci_sig_change u_sig (
		.clk_sys     (clk_sys),
		.resetn      (resetn),
		.tick_ms     (tick_ms),
		.debounce_en (signaling_debounce_en),
		.sig_bits    (sig_bits),
		.change      (signaling_change)
	);

	// ----------------------------------------------------------------
	// set sources of each word
	// ----------------------------------------------------------------
	always_comb begin
		link_set = tci_pkg::WORD_RESET;
		link_set[tci_pkg::POS_FDL_LINK]     = fdl_ctrl_event;
		link_set[tci_pkg::POS_CH24_LINK]    = ch24_ctrl_event;
		link_set[tci_pkg::POS_LOOP_PATTERN] = loop_pattern_event;
		link_set[tci_pkg::POS_ONE_SECOND]   = one_second_flag && !one_second_prev;
		link_set[tci_pkg::POS_FIVE_SECOND]  = five_second_flag && !five_second_prev;
		link_set[tci_pkg::POS_BIT_MESSAGE]  = bit_message_event;
		link_set[tci_pkg::POS_SIGNALING]    = signaling_change;
	end

	always_comb begin
		sets[tci_pkg::IDX_LINE]   = line_event & tci_pkg::LINE_USED;
		sets[tci_pkg::IDX_WRAP]   = wrap_evt;
		sets[tci_pkg::IDX_LINK]   = link_set & tci_pkg::LINK_USED;
		sets[tci_pkg::IDX_LATCH]  = wrap_evt;
		masks[tci_pkg::IDX_LINE]  = line_event_mask;
		masks[tci_pkg::IDX_WRAP]  = counter_wrap_mask;
		masks[tci_pkg::IDX_LINK]  = link_event_mask;
		masks[tci_pkg::IDX_LATCH] = tci_pkg::LATCH_OPEN;
	end

	// ----------------------------------------------------------------
	// processor read decode
	// ----------------------------------------------------------------
	// writes have no target here; other offsets read as zero
	always_comb begin
		next_rdata = tci_pkg::WORD_RESET;
		rd_clr     = 4'h0;
		if (!cpu_rd) begin
			next_rdata = tci_pkg::WORD_RESET;
		end else if (cpu_addr == tci_pkg::ADDR_LINE_EVENT) begin
			next_rdata                = words[tci_pkg::IDX_LINE];
			rd_clr[tci_pkg::IDX_LINE] = 1'b1;
		end else if (cpu_addr == tci_pkg::ADDR_COUNTER_WRAP) begin
			next_rdata                = words[tci_pkg::IDX_WRAP];
			rd_clr[tci_pkg::IDX_WRAP] = 1'b1;
		end else if (cpu_addr == tci_pkg::ADDR_LINK_EVENT) begin
			next_rdata                = words[tci_pkg::IDX_LINK];
			rd_clr[tci_pkg::IDX_LINK] = 1'b1;
		end else if (cpu_addr == tci_pkg::ADDR_WRAP_LATCH) begin
			next_rdata                 = words[tci_pkg::IDX_LATCH];
			rd_clr[tci_pkg::IDX_LATCH] = 1'b1;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			cpu_rdata  <= tci_pkg::WORD_RESET;
			cpu_rvalid <= 1'b0;
		end else begin
			cpu_rdata  <= next_rdata;
			cpu_rvalid <= cpu_rd;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	a_frame_bit_wrap: assert property (@(posedge clk_sys) disable iff (!resetn)
		($past(wrap_cnt[7]) == 8'hff && wrap_cnt[7] == 8'h00 && counter_wrap_mask[7])
		|=> words[1][7])
		else $error("framing bit counter wrap not flagged");

	a_crc6_wrap: assert property (@(posedge clk_sys) disable iff (!resetn)
		($past(wrap_cnt[6]) == 8'hff && wrap_cnt[6] == 8'h00 && counter_wrap_mask[6])
		|=> words[1][6])
		else $error("crc-6 counter wrap not flagged");

	a_oof_wrap: assert property (@(posedge clk_sys) disable iff (!resetn)
		($past(wrap_cnt[5]) == 8'hff && wrap_cnt[5] == 8'h00 && counter_wrap_mask[5])
		|=> words[1][5])
		else $error("out-of-frame counter wrap not flagged");

	a_align_wrap: assert property (@(posedge clk_sys) disable iff (!resetn)
		($past(wrap_cnt[4]) == 8'hff && wrap_cnt[4] == 8'h00 && counter_wrap_mask[4])
		|=> words[1][4])
		else $error("alignment change counter wrap not flagged");

	a_bipolar_wrap: assert property (@(posedge clk_sys) disable iff (!resetn)
		($past(wrap_cnt[3]) == 8'hff && wrap_cnt[3] == 8'h00 && counter_wrap_mask[3])
		|=> words[1][3])
		else $error("bipolar counter wrap not flagged");

	a_pattern_wrap: assert property (@(posedge clk_sys) disable iff (!resetn)
		($past(wrap_cnt[2]) == 8'hff && wrap_cnt[2] == 8'h00 && counter_wrap_mask[2])
		|=> words[1][2])
		else $error("pattern error counter wrap not flagged");

	a_pattern_mf_wrap: assert property (@(posedge clk_sys) disable iff (!resetn)
		($past(wrap_cnt[1]) == 8'hff && wrap_cnt[1] == 8'h00 && counter_wrap_mask[1])
		|=> words[1][1])
		else $error("pattern multiframe counter wrap not flagged");

	a_sync_loss_wrap: assert property (@(posedge clk_sys) disable iff (!resetn)
		($past(wrap_cnt[0]) == 8'hff && wrap_cnt[0] == 8'h00 && counter_wrap_mask[0])
		|=> words[1][0])
		else $error("sync loss counter wrap not flagged");

	a_no_false_wrap: assert property (@(posedge clk_sys) disable iff (!resetn)
		(wrap_cnt[7] != 8'h00) |=> !$rose(words[3][7]))
		else $error("latch set without a wrap");

	a_read_clears: assert property (@(posedge clk_sys) disable iff (!resetn)
		(cpu_rd && cpu_addr == 8'h1d && wrap_evt == 8'h00) |=> words[1] == 8'h00)
		else $error("counter word not cleared by read");

	a_fdl_event: assert property (@(posedge clk_sys) disable iff (!resetn)
		(fdl_ctrl_event && link_event_mask[6]) |=> words[2][6])
		else $error("facility link event missed");

	a_ch24_event: assert property (@(posedge clk_sys) disable iff (!resetn)
		(ch24_ctrl_event && link_event_mask[5]) |=> words[2][5])
		else $error("channel 24 link event missed");

	a_loop_event: assert property (@(posedge clk_sys) disable iff (!resetn)
		(loop_pattern_event && link_event_mask[4]) |=> words[2][4])
		else $error("loop pattern event missed");

	a_one_second: assert property (@(posedge clk_sys) disable iff (!resetn)
		($rose(one_second_flag) && link_event_mask[3]) |=> words[2][3])
		else $error("one second edge missed");

	a_five_second: assert property (@(posedge clk_sys) disable iff (!resetn)
		($rose(five_second_flag) && link_event_mask[2]) |=> words[2][2])
		else $error("five second edge missed");

	a_bit_message: assert property (@(posedge clk_sys) disable iff (!resetn)
		(bit_message_event && link_event_mask[1]) |=> words[2][1])
		else $error("bit message event missed");

	a_sig_raw: assert property (@(posedge clk_sys) disable iff (!resetn)
		(!signaling_debounce_en && !$past(signaling_debounce_en)
		&& sig_bits != $past(sig_bits) && link_event_mask[0])
		|=> ##1 (words[2][0] || !$past(link_event_mask[0])))
		else $error("signaling change not flagged");

	a_unused_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
		!words[0][5] && !words[0][0] && !words[2][7])
		else $error("unused status bit set");

	a_latch_wrap: assert property (@(posedge clk_sys) disable iff (!resetn)
		($past(wrap_cnt[4]) == 8'hff && wrap_cnt[4] == 8'h00) |=> words[3][4])
		else $error("wrap latch not set");

	a_latch_read: assert property (@(posedge clk_sys) disable iff (!resetn)
		(cpu_rd && cpu_addr == 8'h1f)
		|=> cpu_rvalid && cpu_rdata == $past(words[3]) && words[3] == $past(wrap_evt))
		else $error("latch read data or clear wrong");

	a_line_event: assert property (@(posedge clk_sys) disable iff (!resetn)
		(line_event[7] && line_event_mask[7]) |=> words[0][7])
		else $error("line event missed");

	a_reset_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
		$rose(resetn) |-> (words[0] | words[1] | words[2] | words[3]) == 8'h00)
		else $error("status not zero after reset");

endmodule : tci_irq_status

// ---- include/tci_pkg.sv ----
// shared constants for the counter wrap and event interrupt block
package tci_pkg;

	typedef logic [7:0] tci_byte_type;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam tci_byte_type ADDR_LINE_EVENT   = 8'h1c;
	localparam tci_byte_type ADDR_COUNTER_WRAP = 8'h1d;
	localparam tci_byte_type ADDR_LINK_EVENT   = 8'h1e;
	localparam tci_byte_type ADDR_WRAP_LATCH   = 8'h1f;

	// ----------------------------------------------------------------
	// word slots inside the block
	// ----------------------------------------------------------------
	localparam int IDX_LINE  = 0;
	localparam int IDX_WRAP  = 1;
	localparam int IDX_LINK  = 2;
	localparam int IDX_LATCH = 3;
	localparam int NUM_WORDS = 4;

	// ----------------------------------------------------------------
	// reset values and fixed patterns
	// ----------------------------------------------------------------
	localparam tci_byte_type WORD_RESET = 8'h00;
	localparam tci_byte_type WRAP_FROM  = 8'hff;
	localparam tci_byte_type WRAP_TO    = 8'h00;
	localparam tci_byte_type LINE_USED  = 8'hde;
	localparam tci_byte_type LINK_USED  = 8'h7f;
	localparam tci_byte_type LATCH_OPEN = 8'hff;

	// ----------------------------------------------------------------
	// field positions, counter word and latch share one order
	// ----------------------------------------------------------------
	localparam int POS_FRAME_BIT_ERR = 7;
	localparam int POS_CRC6          = 6;
	localparam int POS_OUT_OF_FRAME  = 5;
	localparam int POS_ALIGN_CHANGE  = 4;
	localparam int POS_BIPOLAR_VIOL  = 3;
	localparam int POS_PATTERN_ERR   = 2;
	localparam int POS_PATTERN_MF    = 1;
	localparam int POS_MF_SYNC_LOSS  = 0;
	localparam int POS_FDL_LINK      = 6;
	localparam int POS_CH24_LINK     = 5;
	localparam int POS_LOOP_PATTERN  = 4;
	localparam int POS_ONE_SECOND    = 3;
	localparam int POS_FIVE_SECOND   = 2;
	localparam int POS_BIT_MESSAGE   = 1;
	localparam int POS_SIGNALING     = 0;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 10;
	localparam int MS_TICK_NS      = 1000000;
	localparam int MS_TICK_CYCLES  = MS_TICK_NS / CLK_PERIOD_NS;
	localparam int SIG_DEBOUNCE_MS = 6;

endpackage : tci_pkg

// ---- include/tci_word_if.sv ----
// carrier between the top and one sticky status word
interface tci_word_if;
	logic [7:0] set;
	logic [7:0] mask;
	logic       clr;
	logic [7:0] word;
	modport holder (input set, input mask, input clr, output word);
	modport user (output set, output mask, output clr, input word);
endinterface : tci_word_if

// ---- core/tci_sticky_word.sv ----
// one read-to-clear sticky status word
module tci_sticky_word (
	// clock and reset
	input wire logic   clk_sys,
	input wire logic   resetn,
	// word port
	tci_word_if.holder wp
);

	logic [7:0] next_word;
	logic [7:0] gated_set;

	// set wins over a clear in the same cycle
	always_comb begin
		gated_set = wp.set & wp.mask;
		next_word = (wp.word & ~{8{wp.clr}}) | gated_set;
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			wp.word <= tci_pkg::WORD_RESET;
		end else begin
			wp.word <= next_word;
		end
	end

	a_set_beats_clear: assert property (@(posedge clk_sys) disable iff (!resetn)
		(wp.clr && (wp.set & wp.mask) != 8'h00)
		|=> ((wp.word & $past(gated_set)) == $past(gated_set)))
		else $error("event lost on clearing read");

	a_masked_stays_low: assert property (@(posedge clk_sys) disable iff (!resetn)
		((wp.word & ~$past(wp.word) & ~$past(wp.mask)) == 8'h00))
		else $error("status bit set while masked");

endmodule : tci_sticky_word

// ---- core/tci_sig_change.sv ----
// signaling pattern change detector with optional debounce
module tci_sig_change (
	// clock and reset
	input wire logic       clk_sys,
	input wire logic       resetn,
	// timing and control
	input wire logic       tick_ms,
	input wire logic       debounce_en,
	// received pattern
	input wire logic [3:0] sig_bits,
	// result
	output logic           change
);

	localparam logic [2:0] DEB_TICKS = 3'(tci_pkg::SIG_DEBOUNCE_MS);

	logic [3:0] last;
	logic [3:0] cand;
	logic [2:0] stable_cnt;
	logic       accept;

	// ------------------------------------------------------------
	// candidate pattern and its stability count
	// ------------------------------------------------------------
	// first tick may be partial, so stability is one ms short at worst
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			cand       <= 4'h0;
			stable_cnt <= 3'h0;
		end else if (sig_bits != cand) begin
			cand       <= sig_bits;
			stable_cnt <= 3'h0;
		end else if (tick_ms && stable_cnt != DEB_TICKS) begin
			stable_cnt <= stable_cnt + 3'h1;
		end
	end

	always_comb begin
		if (debounce_en) begin
			accept = (stable_cnt == DEB_TICKS) && (cand != last);
		end else begin
			accept = (sig_bits != last);
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			last <= 4'h0;
		end else if (accept) begin
			last <= debounce_en ? cand : sig_bits;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			change <= 1'b0;
		end else begin
			change <= accept;
		end
	end

	a_raw_change: assert property (@(posedge clk_sys) disable iff (!resetn)
		(!debounce_en && !$past(debounce_en) && sig_bits != $past(sig_bits)) |=> change)
		else $error("undebounced signaling change missed");

endmodule : tci_sig_change

// ---- verification/test_t1_counter_overflow_and_event_irq.sv ----
// self-checking bench for the counter wrap and event interrupt block
module test_t1_counter_overflow_and_event_irq;
	timeunit 1ns;
	timeprecision 100ps;

	// ------------------------------------------------------------
	// signals and bookkeeping
	// ------------------------------------------------------------
	typedef struct packed {
		logic [4:0] src;
		logic [7:0] mask;
	} tci_row_type;

	logic            clk_sys               = 1'b0;
	logic            resetn                = 1'b0;
	logic            cpu_rd                = 1'b0;
	logic [7:0]      cpu_addr              = 8'h00;
	logic [7:0]      cpu_rdata;
	logic            cpu_rvalid;
	logic [7:0]      line_event_mask       = 8'h00;
	logic [7:0]      counter_wrap_mask     = 8'h00;
	logic [7:0]      link_event_mask       = 8'h00;
	logic [7:0][7:0] wrap_cnt              = '0;
	logic [7:0]      line_event            = 8'h00;
	logic [6:0]      link_src              = 7'h00;
	logic [3:0]      sig_bits              = 4'h0;
	logic            signaling_debounce_en = 1'b0;
	int              fails                 = 0;
	int              cmp_count             = 0;

	// src 0-7 counter wrap, 9-14 link word bit src-8, 16-23 line word bit src-16
	tci_row_type rows [24] = '{'{5'd0, 8'hff}, '{5'd1, 8'hff}, '{5'd2, 8'hff}, '{5'd3, 8'hff},
		'{5'd4, 8'hff}, '{5'd5, 8'hff}, '{5'd6, 8'hff}, '{5'd7, 8'hff}, '{5'd3, 8'hf7},
		'{5'd9, 8'hff}, '{5'd10, 8'hff}, '{5'd11, 8'hff}, '{5'd12, 8'hff}, '{5'd13, 8'hff},
		'{5'd14, 8'hff}, '{5'd11, 8'h00}, '{5'd16, 8'hff}, '{5'd17, 8'hff}, '{5'd18, 8'hff},
		'{5'd19, 8'hff}, '{5'd20, 8'hff}, '{5'd21, 8'hff}, '{5'd22, 8'hff}, '{5'd23, 8'hff}};

	always #5 clk_sys = ~clk_sys;

	tci_irq_status #(.TICK_CYCLES(8)) dut_u (
		.clk_sys               (clk_sys),
		.resetn                (resetn),
		.cpu_rd                (cpu_rd),
		.cpu_addr              (cpu_addr),
		.cpu_rdata             (cpu_rdata),
		.cpu_rvalid            (cpu_rvalid),
		.line_event_mask       (line_event_mask),
		.counter_wrap_mask     (counter_wrap_mask),
		.link_event_mask       (link_event_mask),
		.wrap_cnt              (wrap_cnt),
		.line_event            (line_event),
		.fdl_ctrl_event        (link_src[6]),
		.ch24_ctrl_event       (link_src[5]),
		.loop_pattern_event    (link_src[4]),
		.one_second_flag       (link_src[3]),
		.five_second_flag      (link_src[2]),
		.bit_message_event     (link_src[1]),
		.sig_bits              (sig_bits),
		.signaling_debounce_en (signaling_debounce_en)
	);

	// ------------------------------------------------------------
	// tasks
	// ------------------------------------------------------------
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		cmp_count++;
		if (got !== exp) begin
			fails++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	// entered and left on a rising edge
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		int n;
		cpu_rd   <= 1'b1;
		cpu_addr <= a;
		@(posedge clk_sys);
		cpu_rd <= 1'b0;
		for (n = 1; n < 4; n++) begin
			#1;
			if (cpu_rvalid === 1'b1) break;
			@(posedge clk_sys);
		end
		if (n == 4) begin
			fails++;
			$display("mismatch at %0t: read answer missing", $time);
			print_verdict();
		end else begin
			chk(8'(n), 8'h01, "read latency");
			chk(cpu_rdata, exp, "read data");
			@(posedge clk_sys);
		end
	endtask : rd

	task automatic fire(input logic [4:0] src);
		if (src < 5'd8) begin
			wrap_cnt[src[2:0]] <= 8'hff;
			@(posedge clk_sys);
			wrap_cnt[src[2:0]] <= 8'h00;
		end else if (src < 5'd16) begin
			link_src[src[2:0]] <= 1'b1;
		end else begin
			line_event[src[2:0]] <= 1'b1;
		end
		@(posedge clk_sys);
		line_event <= 8'h00;
		// second flags stay high so a held level can be seen not to re-arm
		link_src   <= link_src & 7'h0c;
	endtask : fire

	task automatic all_clear();
		for (int a = 8'h1c; a <= 8'h1f; a++) begin
			rd(8'(a), tci_pkg::WORD_RESET);
		end
	endtask : all_clear

	// ------------------------------------------------------------
	// main sequence
	// ------------------------------------------------------------
	initial begin
		logic [7:0] a;
		logic [7:0] exp;
		int         pos;
		repeat (3) @(posedge clk_sys);
		resetn <= 1'b1;
		all_clear();
		$display("test reset values done");

		foreach (rows[i]) begin
			line_event_mask   <= rows[i].mask;
			counter_wrap_mask <= rows[i].mask;
			link_event_mask   <= rows[i].mask;
			@(posedge clk_sys);
			fire(rows[i].src);
			pos = int'(rows[i].src[2:0]);
			exp = rows[i].mask & (8'h01 << pos);
			if (rows[i].src < 5'd8) begin
				a = tci_pkg::ADDR_COUNTER_WRAP;
				rd(a, exp);
				rd(tci_pkg::ADDR_WRAP_LATCH, 8'h01 << pos);
				rd(tci_pkg::ADDR_WRAP_LATCH, 8'h00);
			end else if (rows[i].src < 5'd16) begin
				a = tci_pkg::ADDR_LINK_EVENT;
				rd(a, exp & tci_pkg::LINK_USED);
			end else begin
				a = tci_pkg::ADDR_LINE_EVENT;
				rd(a, exp & tci_pkg::LINE_USED);
			end
			rd(a, 8'h00);
			link_src <= 7'h00;
		end
		$display("test table rows done");

		rd(8'h1b, 8'h00);
		rd(8'h20, 8'h00);
		$display("test unmapped offsets done");

		// wrap completes on the very edge that takes the clearing read
		counter_wrap_mask <= 8'hff;
		wrap_cnt[7]       <= 8'hff;
		@(posedge clk_sys);
		wrap_cnt[7] <= 8'h00;
		rd(tci_pkg::ADDR_COUNTER_WRAP, 8'h00);
		rd(tci_pkg::ADDR_COUNTER_WRAP, 8'h80);
		rd(tci_pkg::ADDR_WRAP_LATCH, 8'h80);
		$display("test set over clear done");

		fire(5'd0);
		fire(5'd14);
		fire(5'd16 + 5'(tci_pkg::POS_CRC6));
		resetn <= 1'b0;
		repeat (3) @(posedge clk_sys);
		resetn <= 1'b1;
		all_clear();
		$display("test mid-run reset done");

		sig_bits <= 4'h5;
		repeat (4) @(posedge clk_sys);
		rd(tci_pkg::ADDR_LINK_EVENT, 8'h01);
		rd(tci_pkg::ADDR_LINK_EVENT, 8'h00);
		// a short excursion must be swallowed when debounce is on
		signaling_debounce_en <= 1'b1;
		sig_bits              <= 4'ha;
		repeat (16) @(posedge clk_sys);
		sig_bits <= 4'h5;
		repeat (80) @(posedge clk_sys);
		rd(tci_pkg::ADDR_LINK_EVENT, 8'h00);
		sig_bits <= 4'ha;
		repeat (30) @(posedge clk_sys);
		rd(tci_pkg::ADDR_LINK_EVENT, 8'h00);
		repeat (40) @(posedge clk_sys);
		rd(tci_pkg::ADDR_LINK_EVENT, 8'h01);
		$display("test signaling change done");
		print_verdict();
	end

endmodule : test_t1_counter_overflow_and_event_irq
